/* rtl/flpes_pkg.sv */
// constants, codes and state encoding of the flash program/erase sequencer
package flpes_pkg;

	// command codes; the three program commands carry the segment in the low nibble
	localparam logic [11:0] CMD_WORD       = 12'h55a;
	localparam logic [11:0] CMD_DWORD      = 12'hdd4;
	localparam logic [11:0] CMD_BLOCK      = 12'haa5;
	localparam logic [15:0] CMD_ERASE      = 16'heeee;
	localparam logic [15:0] CMD_STATUS     = 16'h7777;
	localparam logic [15:0] ERASE_KEY      = 16'h5555;

	// result codes returned in r0
	localparam logic [7:0]  RES_OK         = 8'h00;
	localparam logic [7:0]  RES_NOT_EN     = 8'h01;
	localparam logic [7:0]  RES_NO_VPP     = 8'h02;
	localparam logic [7:0]  RES_FAIL       = 8'h03;
	localparam logic [7:0]  RES_BAD_ADDR   = 8'h04;
	localparam logic [7:0]  RES_BAD_CMD    = 8'h05;

	// cpu address map of the array
	localparam logic [23:0] SEG0_LOW_BASE  = 24'h00_0000;
	localparam logic [23:0] SEG1_LOW_BASE  = 24'h01_0000;
	localparam logic [23:0] LOW_LAST_OFS   = 24'h00_7fff;
	localparam logic [23:0] HIGH_FIRST     = 24'h01_8000;
	localparam logic [23:0] HIGH_LAST      = 24'h02_ffff;
	localparam logic [23:0] HIGH_SHIFT     = 24'h01_0000;

	// bank bounds as 32-bit word indexes of the array (8K, 24K, 48K, 48K bytes)
	localparam logic [14:0] BANK_FIRST_W [4] = '{15'h0000, 15'h0800, 15'h2000, 15'h5000};
	localparam logic [14:0] BANK_LAST_W  [4] = '{15'h07ff, 15'h1fff, 15'h4fff, 15'h7fff};
	localparam logic [15:0] BANK_COUNT     = 16'h0004;

	// block programming span limit in bytes
	localparam logic [15:0] BLOCK_SPAN     = 16'h4000;

	// pulse widths in ns, timed with the cpu period given
	localparam logic [31:0] PROG_PULSE_NS  = 32'h0000_2710;
	localparam logic [31:0] ERASE_PULSE_NS = 32'h0098_9680;
	localparam logic [7:0]  MAX_PROG_TRY   = 8'h19;
	localparam logic [7:0]  MAX_ERASE_TRY  = 8'h64;
	localparam logic [1:0]  READ_WAIT      = 2'h2;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0000,
		ST_CHECK = 4'b0001,
		ST_SRC   = 4'b0011,
		ST_PROG  = 4'b0010,
		ST_PVER  = 4'b0110,
		ST_NEXT  = 4'b0111,
		ST_READ  = 4'b0101,
		ST_ERASE = 4'b0100,
		ST_EVER  = 4'b1100,
		ST_DONE  = 4'b1101
	} flpes_state_e;

	typedef enum logic [1:0] {
		OP_WORD  = 2'b00,
		OP_DWORD = 2'b01,
		OP_BLOCK = 2'b11,
		OP_ERASE = 2'b10
	} flpes_op_e;

endpackage : flpes_pkg

/* rtl/flpes_addr_map.sv */
// maps a cpu address onto the flash array, following the low-bank segment choice
module flpes_addr_map (
	// address in
	input  wire logic [23:0] addr_in,
	input  wire logic        seg1_map_in,
	// decoded
	output logic             hit_out,
	output logic [16:0]      phys_out
);
	logic [23:0] low_base;
	logic [23:0] high_ofs;

	always_comb begin
		low_base = seg1_map_in ? flpes_pkg::SEG1_LOW_BASE : flpes_pkg::SEG0_LOW_BASE;
		high_ofs = addr_in - flpes_pkg::HIGH_SHIFT;
		hit_out  = 1'b0;
		phys_out = 17'h0_0000;
		if (addr_in >= low_base && addr_in <= low_base + flpes_pkg::LOW_LAST_OFS) begin
			hit_out  = 1'b1;
			phys_out = {2'b00, addr_in[14:0]};
		end else if (addr_in >= flpes_pkg::HIGH_FIRST && addr_in <= flpes_pkg::HIGH_LAST) begin
			hit_out  = 1'b1;
			phys_out = high_ofs[16:0];
		end
	end

endmodule : flpes_addr_map

/* rtl/flpes_sequencer.sv */
// flash program/erase sequencer: unlock, command check, pulse timing, verify
// What this block does
// - array read as 32-bit double-word lines
// - four banks 8K/24K/48K/48K, erased one at a time
// - low banks mapped to segment 0 or 1 at init
// - no normal flash access while operation runs
// - protection blocks external viewing, execution continues
// - only unlock sequence starts; kernel checks, decodes, executes
// - program pulse timed from cpu period, then verified
// - erase pre-programs bank, times pulses, verifies erasure
// - single word: 55As, offset, data, period
// - double word: DD4s, offset, low, high, period
// - block: AA5s, first, last, source, period
// - bank erase: EEEE, key 5555, bank twice, period
// - status read: 7777, only return values
// - result code in r0: 00 to 05
module flpes_sequencer #(
	parameter logic [31:0] ERASE_PULSE_NS = flpes_pkg::ERASE_PULSE_NS
) (
	// clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        resetn_in,
	// configuration straps and levels
	input  wire logic        seg1_strap_in,
	input  wire logic        flash_enable_bit_in,
	input  wire logic        vpp_present_in,
	input  wire logic        protect_in,
	// unlock writes and command registers
	input  wire logic        unlock_wr_in,
	input  wire logic        unlock_indirect_in,
	input  wire logic [23:0] unlock_addr_in,
	input  wire logic [15:0] r0_in,
	input  wire logic [15:0] r1_in,
	input  wire logic [15:0] r2_in,
	input  wire logic [15:0] r3_in,
	input  wire logic [15:0] r4_in,
	// command results
	output logic             busy_out,
	output logic             done_out,
	output logic [7:0]       result_out,
	output logic [15:0]      ret_r1_out,
	output logic [15:0]      ret_r2_out,
	output logic [15:0]      ret_r3_out,
	// source data fetch for block programming
	output logic             src_req_out,
	output logic [15:0]      src_addr_out,
	input  wire logic        src_ack_in,
	input  wire logic [15:0] src_data_in,
	// normal cpu access
	input  wire logic        cpu_req_in,
	input  wire logic [23:0] cpu_addr_in,
	input  wire logic        cpu_fetch_in,
	input  wire logic        cpu_ext_view_in,
	output logic             cpu_hit_out,
	output logic             cpu_ack_out,
	output logic             cpu_blocked_out,
	output logic [31:0]      cpu_rdata_out,
	output logic             ram_view_block_out,
	output logic             seg1_map_out,
	// flash array macro
	output logic [14:0]      fl_addr_out,
	output logic [31:0]      fl_wdata_out,
	output logic [1:0]       fl_wmask_out,
	output logic             fl_prog_out,
	output logic             fl_erase_out,
	output logic [1:0]       fl_erase_bank_out,
	input  wire logic [31:0] fl_rdata_in
);

	flpes_pkg::flpes_state_e st_r, st_nxt;
	flpes_pkg::flpes_op_e    op_r, op_nxt;
	logic [15:0] r0_r, r0_nxt, r1_r, r1_nxt, r2_r, r2_nxt, r3_r, r3_nxt, r4_r, r4_nxt;
	logic [16:0] cur_r, cur_nxt, end_r, end_nxt;
	logic [31:0] wdata_r, wdata_nxt, ns_r, ns_nxt, ns_sum;
	logic [1:0]  mask_r, mask_nxt, bank_r, bank_nxt, wait_r, wait_nxt;
	logic [7:0]  try_r, try_nxt, etry_r, etry_nxt, result_r, result_nxt;
	logic [15:0] ret1_r, ret1_nxt, ret2_r, ret2_nxt, ret3_r, ret3_nxt;
	logic [15:0] src_r, src_nxt;
	logic        phase_r, phase_nxt, armed_r, armed_nxt, seg1_r, seg1_nxt;
	logic        init_r, init_nxt;
	logic [23:0] ulk_addr_r, ulk_addr_nxt;
	logic        trigger;
	logic        cpu_hit, beg_hit, end_hit, ulk_hit;
	logic [16:0] cpu_phys, beg_phys, end_phys;
	logic [15:0] span;
	logic [31:0] diff;

	//////////////////////////////////////////////////////////////////////////
	// address decode
	flpes_addr_map u_map_cpu (
		.addr_in     (cpu_addr_in),
		.seg1_map_in (seg1_r),
		.hit_out     (cpu_hit),
		.phys_out    (cpu_phys)
	);
	flpes_addr_map u_map_beg (
		.addr_in     ({4'h0, r0_r[3:0], r1_r}),
		.seg1_map_in (seg1_r),
		.hit_out     (beg_hit),
		.phys_out    (beg_phys)
	);
	flpes_addr_map u_map_end (
		.addr_in     ({4'h0, r0_r[3:0], r2_r}),
		.seg1_map_in (seg1_r),
		.hit_out     (end_hit),
		.phys_out    (end_phys)
	);
	flpes_addr_map u_map_ulk (
		.addr_in     (unlock_addr_in),
		.seg1_map_in (seg1_r),
		.hit_out     (ulk_hit),
		.phys_out    ()
	);

	//////////////////////////////////////////////////////////////////////////
	// unlock sequence and segment map capture
	always_comb begin
		seg1_nxt     = init_r ? seg1_r : seg1_strap_in;
		init_nxt     = 1'b1;
		armed_nxt    = armed_r;
		ulk_addr_nxt = ulk_addr_r;
		trigger      = 1'b0;
		if (unlock_wr_in) begin
			armed_nxt = 1'b0;
			if (unlock_indirect_in && armed_r && unlock_addr_in == ulk_addr_r &&
			    st_r == flpes_pkg::ST_IDLE) begin
				trigger = 1'b1;
			end else if (!unlock_indirect_in && ulk_hit && !unlock_addr_in[0]) begin
				armed_nxt    = 1'b1;
				ulk_addr_nxt = unlock_addr_in;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			seg1_r     <= 1'b0;
			init_r     <= 1'b0;
			armed_r    <= 1'b0;
			ulk_addr_r <= 24'h00_0000;
		end else begin
			seg1_r     <= seg1_nxt;
			init_r     <= init_nxt;
			armed_r    <= armed_nxt;
			ulk_addr_r <= ulk_addr_nxt;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// kernel state machine
	always_comb begin
		st_nxt = st_r;     op_nxt = op_r;       cur_nxt = cur_r;     end_nxt = end_r;
		r0_nxt = r0_r;     r1_nxt = r1_r;       r2_nxt = r2_r;       r3_nxt = r3_r;
		r4_nxt = r4_r;     wdata_nxt = wdata_r; mask_nxt = mask_r;   bank_nxt = bank_r;
		ns_nxt = ns_r;     try_nxt = try_r;     etry_nxt = etry_r;   phase_nxt = phase_r;
		wait_nxt = wait_r; src_nxt = src_r;     result_nxt = result_r;
		ret1_nxt = ret1_r; ret2_nxt = ret2_r;   ret3_nxt = ret3_r;
		ns_sum = ns_r + {16'h0000, r4_r};
		span   = r2_r - r1_r;
		diff   = fl_rdata_in ^ wdata_r;
		unique case (st_r)
			flpes_pkg::ST_IDLE: begin
				if (trigger) begin
					{r0_nxt, r1_nxt, r2_nxt, r3_nxt, r4_nxt} = {r0_in, r1_in, r2_in, r3_in, r4_in};
					st_nxt = flpes_pkg::ST_CHECK;
				end
			end
			flpes_pkg::ST_CHECK: begin
				st_nxt = flpes_pkg::ST_DONE;
				try_nxt = 8'h00;
				ns_nxt = 32'h0000_0000;
				if (r0_r == flpes_pkg::CMD_STATUS) begin
					result_nxt = flpes_pkg::RES_OK;
					ret1_nxt = {8'h00, result_r};
					ret2_nxt = {13'h0000, protect_in, seg1_r, flash_enable_bit_in};
					ret3_nxt = {15'h0000, vpp_present_in};
				end else if (r0_r[15:4] != flpes_pkg::CMD_WORD &&
				             r0_r[15:4] != flpes_pkg::CMD_DWORD &&
				             r0_r[15:4] != flpes_pkg::CMD_BLOCK && r0_r != flpes_pkg::CMD_ERASE) begin
					result_nxt = flpes_pkg::RES_BAD_CMD;
				end else if (!flash_enable_bit_in) begin
					result_nxt = flpes_pkg::RES_NOT_EN;
				end else if (!vpp_present_in) begin
					result_nxt = flpes_pkg::RES_NO_VPP;
				end else if (r0_r == flpes_pkg::CMD_ERASE) begin
					if (r1_r != flpes_pkg::ERASE_KEY || r2_r != r3_r ||
					    r2_r >= flpes_pkg::BANK_COUNT) begin
						result_nxt = flpes_pkg::RES_BAD_CMD;
					end else begin
						op_nxt    = flpes_pkg::OP_ERASE;
						bank_nxt  = r2_r[1:0];
						cur_nxt   = {flpes_pkg::BANK_FIRST_W[r2_r[1:0]], 2'b00};
						end_nxt   = {flpes_pkg::BANK_LAST_W[r2_r[1:0]], 2'b00};
						phase_nxt = 1'b0;
						etry_nxt  = 8'h00;
						wait_nxt  = flpes_pkg::READ_WAIT;
						st_nxt    = flpes_pkg::ST_READ;
					end
				end else if (!beg_hit || r1_r[0] ||
				             (r0_r[15:4] == flpes_pkg::CMD_DWORD && r1_r[1]) ||
				             (r0_r[15:4] == flpes_pkg::CMD_BLOCK &&
				              (!end_hit || r2_r[0] || r2_r < r1_r ||
				               span >= flpes_pkg::BLOCK_SPAN))) begin
					result_nxt = flpes_pkg::RES_BAD_ADDR;
				end else begin
					cur_nxt = beg_phys;
					end_nxt = beg_phys;
					st_nxt  = flpes_pkg::ST_PROG;
					if (r0_r[15:4] == flpes_pkg::CMD_WORD) begin
						op_nxt    = flpes_pkg::OP_WORD;
						wdata_nxt = beg_phys[1] ? {r2_r, 16'hffff} : {16'hffff, r2_r};
						mask_nxt  = beg_phys[1] ? 2'b10 : 2'b01;
					end else if (r0_r[15:4] == flpes_pkg::CMD_DWORD) begin
						op_nxt    = flpes_pkg::OP_DWORD;
						wdata_nxt = {r3_r, r2_r};
						mask_nxt  = 2'b11;
					end else begin
						op_nxt  = flpes_pkg::OP_BLOCK;
						end_nxt = end_phys;
						src_nxt = r3_r;
						st_nxt  = flpes_pkg::ST_SRC;
					end
				end
			end
			flpes_pkg::ST_SRC: begin
				if (src_ack_in) begin
					wdata_nxt = cur_r[1] ? {src_data_in, 16'hffff} : {16'hffff, src_data_in};
					mask_nxt  = cur_r[1] ? 2'b10 : 2'b01;
					src_nxt   = src_r + 16'h0002;
					try_nxt   = 8'h00;
					ns_nxt    = 32'h0000_0000;
					st_nxt    = flpes_pkg::ST_PROG;
				end
			end
			flpes_pkg::ST_PROG: begin
				ns_nxt = ns_sum;
				if (ns_sum >= flpes_pkg::PROG_PULSE_NS) begin
					try_nxt  = try_r + 8'h01;
					wait_nxt = flpes_pkg::READ_WAIT;
					st_nxt   = flpes_pkg::ST_PVER;
				end
			end
			flpes_pkg::ST_PVER: begin
				wait_nxt = wait_r - 2'h1;
				if (wait_r == 2'h0) begin
					wait_nxt = 2'h0;
					ns_nxt   = 32'h0000_0000;
					if ((diff & {{16{mask_r[1]}}, {16{mask_r[0]}}}) == 32'h0000_0000) begin
						st_nxt = flpes_pkg::ST_NEXT;
					end else if (try_r < flpes_pkg::MAX_PROG_TRY) begin
						st_nxt = flpes_pkg::ST_PROG;
					end else begin
						result_nxt = flpes_pkg::RES_FAIL;
						st_nxt     = flpes_pkg::ST_DONE;
					end
				end
			end
			flpes_pkg::ST_READ: begin
				wait_nxt = wait_r - 2'h1;
				if (wait_r == 2'h0) begin
					wait_nxt = 2'h0;
					if (fl_rdata_in != 32'h0000_0000) begin
						wdata_nxt = 32'h0000_0000;
						mask_nxt  = 2'b11;
						try_nxt   = 8'h00;
						ns_nxt    = 32'h0000_0000;
						st_nxt    = flpes_pkg::ST_PROG;
					end else begin
						st_nxt = flpes_pkg::ST_NEXT;
					end
				end
			end
			flpes_pkg::ST_NEXT: begin
				if (cur_r == end_r) begin
					if (op_r == flpes_pkg::OP_ERASE && !phase_r) begin
						ns_nxt = 32'h0000_0000;
						st_nxt = flpes_pkg::ST_ERASE;
					end else begin
						result_nxt = flpes_pkg::RES_OK;
						st_nxt     = flpes_pkg::ST_DONE;
					end
				end else if (op_r == flpes_pkg::OP_BLOCK) begin
					cur_nxt = cur_r + 17'h0_0002;
					st_nxt  = flpes_pkg::ST_SRC;
				end else begin
					cur_nxt  = cur_r + 17'h0_0004;
					wait_nxt = flpes_pkg::READ_WAIT;
					st_nxt   = phase_r ? flpes_pkg::ST_EVER : flpes_pkg::ST_READ;
				end
			end
			flpes_pkg::ST_ERASE: begin
				ns_nxt = ns_sum;
				if (ns_sum >= ERASE_PULSE_NS) begin
					etry_nxt  = etry_r + 8'h01;
					phase_nxt = 1'b1;
					cur_nxt   = {flpes_pkg::BANK_FIRST_W[bank_r], 2'b00};
					wait_nxt  = flpes_pkg::READ_WAIT;
					st_nxt    = flpes_pkg::ST_EVER;
				end
			end
			flpes_pkg::ST_EVER: begin
				wait_nxt = wait_r - 2'h1;
				if (wait_r == 2'h0) begin
					wait_nxt = 2'h0;
					ns_nxt   = 32'h0000_0000;
					if (fl_rdata_in == 32'hffff_ffff) begin
						st_nxt = flpes_pkg::ST_NEXT;
					end else if (etry_r < flpes_pkg::MAX_ERASE_TRY) begin
						st_nxt = flpes_pkg::ST_ERASE;
					end else begin
						result_nxt = flpes_pkg::RES_FAIL;
						st_nxt     = flpes_pkg::ST_DONE;
					end
				end
			end
			flpes_pkg::ST_DONE: begin
				st_nxt = flpes_pkg::ST_IDLE;
			end
			default: begin
				st_nxt = flpes_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			st_r <= flpes_pkg::ST_IDLE;    op_r <= flpes_pkg::OP_WORD;
			r0_r <= 16'h0000;              r1_r <= 16'h0000;        r2_r <= 16'h0000;
			r3_r <= 16'h0000;              r4_r <= 16'h0000;        cur_r <= 17'h0_0000;
			end_r <= 17'h0_0000;           wdata_r <= 32'hffff_ffff; mask_r <= 2'b00;
			bank_r <= 2'b00;               ns_r <= 32'h0000_0000;   try_r <= 8'h00;
			etry_r <= 8'h00;               phase_r <= 1'b0;         wait_r <= 2'h0;
			src_r <= 16'h0000;             result_r <= flpes_pkg::RES_OK;
			ret1_r <= 16'h0000;            ret2_r <= 16'h0000;      ret3_r <= 16'h0000;
		end else begin
			st_r <= st_nxt;                op_r <= op_nxt;
			r0_r <= r0_nxt;                r1_r <= r1_nxt;          r2_r <= r2_nxt;
			r3_r <= r3_nxt;                r4_r <= r4_nxt;          cur_r <= cur_nxt;
			end_r <= end_nxt;              wdata_r <= wdata_nxt;    mask_r <= mask_nxt;
			bank_r <= bank_nxt;            ns_r <= ns_nxt;          try_r <= try_nxt;
			etry_r <= etry_nxt;            phase_r <= phase_nxt;    wait_r <= wait_nxt;
			src_r <= src_nxt;              result_r <= result_nxt;
			ret1_r <= ret1_nxt;            ret2_r <= ret2_nxt;      ret3_r <= ret3_nxt;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// normal access path and array address
	logic [14:0] fl_addr_r, fl_addr_nxt;
	logic [1:0]  pend_r, pend_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic        ack_r, ack_nxt, blk_r, blk_nxt, view_r, view_nxt;

	always_comb begin
		fl_addr_nxt = fl_addr_r;
		pend_nxt    = {pend_r[0], 1'b0};
		view_nxt    = view_r;
		rdata_nxt   = rdata_r;
		ack_nxt     = 1'b0;
		blk_nxt     = 1'b0;
		if (st_nxt != flpes_pkg::ST_IDLE) begin
			fl_addr_nxt = cur_nxt[16:2];
		end else if (cpu_req_in && cpu_hit && pend_r == 2'b00) begin
			fl_addr_nxt = cpu_phys[16:2];
		end
		if (cpu_req_in && cpu_hit) begin
			if (st_r != flpes_pkg::ST_IDLE || pend_r != 2'b00) begin
				blk_nxt   = 1'b1;
				rdata_nxt = 32'h0000_0000;
			end else begin
				pend_nxt[0] = 1'b1;
				view_nxt    = protect_in && cpu_ext_view_in && !cpu_fetch_in;
			end
		end
		if (pend_r[1]) begin
			if (st_r != flpes_pkg::ST_IDLE || view_r) begin
				blk_nxt   = 1'b1;
				rdata_nxt = 32'h0000_0000;
			end else begin
				ack_nxt   = 1'b1;
				rdata_nxt = fl_rdata_in;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			fl_addr_r <= 15'h0000;
			pend_r    <= 2'b00;
			rdata_r   <= 32'h0000_0000;
			ack_r     <= 1'b0;
			blk_r     <= 1'b0;
			view_r    <= 1'b0;
		end else begin
			fl_addr_r <= fl_addr_nxt;
			pend_r    <= pend_nxt;
			rdata_r   <= rdata_nxt;
			ack_r     <= ack_nxt;
			blk_r     <= blk_nxt;
			view_r    <= view_nxt;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// outputs
	assign busy_out           = st_r != flpes_pkg::ST_IDLE;
	assign done_out           = st_r == flpes_pkg::ST_DONE;
	assign result_out         = result_r;
	assign ret_r1_out         = ret1_r;
	assign ret_r2_out         = ret2_r;
	assign ret_r3_out         = ret3_r;
	assign src_req_out        = st_r == flpes_pkg::ST_SRC;
	assign src_addr_out       = src_r;
	assign cpu_hit_out        = cpu_hit;
	assign cpu_ack_out        = ack_r;
	assign cpu_blocked_out    = blk_r;
	assign cpu_rdata_out      = rdata_r;
	assign ram_view_block_out = protect_in;
	assign seg1_map_out       = seg1_r;
	assign fl_addr_out        = fl_addr_r;
	assign fl_wdata_out       = wdata_r;
	assign fl_wmask_out       = mask_r;
	assign fl_prog_out        = st_r == flpes_pkg::ST_PROG;
	assign fl_erase_out       = st_r == flpes_pkg::ST_ERASE;
	assign fl_erase_bank_out  = bank_r;

endmodule : flpes_sequencer

/* test/flpes_flash_model.sv */
// flash array macro and block source memory model
module flpes_flash_model (
	// flash array side
	input  wire logic        ref_clk_in,
	input  wire logic [14:0] fl_addr_out,
	input  wire logic [31:0] fl_wdata_out,
	input  wire logic [1:0]  fl_wmask_out,
	input  wire logic        fl_prog_out,
	input  wire logic        fl_erase_out,
	input  wire logic [1:0]  fl_erase_bank_out,
	output logic      [31:0] fl_rdata_in,
	// source data side
	input  wire logic        src_req_out,
	input  wire logic [15:0] src_addr_out,
	output logic             src_ack_in,
	output logic      [15:0] src_data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [32768];
	logic        ers_r;
	logic [1:0]  wt_r;
	initial begin
		foreach (mem[i]) mem[i] = 32'hffff_ffff;
		ers_r = 1'b0;
		wt_r = 2'h0;
	end
	always @(posedge ref_clk_in) begin
		fl_rdata_in <= mem[fl_addr_out];
		ers_r <= fl_erase_out;
		// programming only clears bits
		if (fl_prog_out && fl_wmask_out[0])
			mem[fl_addr_out][15:0] = mem[fl_addr_out][15:0] & fl_wdata_out[15:0];
		if (fl_prog_out && fl_wmask_out[1])
			mem[fl_addr_out][31:16] = mem[fl_addr_out][31:16] & fl_wdata_out[31:16];
		// erase touches one bank only
		if (fl_erase_out && !ers_r)
			for (int i = int'(flpes_pkg::BANK_FIRST_W[fl_erase_bank_out]);
					i <= int'(flpes_pkg::BANK_LAST_W[fl_erase_bank_out]); i++)
				mem[i] = 32'hffff_ffff;
		// slow source answer, data line toggles when idle
		wt_r <= (src_req_out && !src_ack_in) ? wt_r + 2'h1 : 2'h0;
		src_ack_in <= src_req_out && !src_ack_in && wt_r == 2'h2;
		src_data_in <= (src_req_out && wt_r == 2'h2) ? src_addr_out ^ 16'ha5a5 : ~src_data_in;
	end
endmodule : flpes_flash_model

/* test/flpes_sequencer_properties.sv */
// port-level checker of the flash program/erase sequencer
module flpes_sequencer_properties (
	input wire logic        ref_clk_in,
	input wire logic        resetn_in,
	input wire logic        protect_in,
	input wire logic        cpu_req_in,
	input wire logic        cpu_fetch_in,
	input wire logic        cpu_ext_view_in,
	input wire logic        cpu_hit_out,
	input wire logic        busy_out,
	input wire logic        done_out,
	input wire logic [7:0]  result_out,
	input wire logic        cpu_ack_out,
	input wire logic        cpu_blocked_out,
	input wire logic [31:0] cpu_rdata_out,
	input wire logic        ram_view_block_out,
	input wire logic        src_req_out,
	input wire logic        src_ack_in,
	input wire logic [15:0] src_addr_out,
	input wire logic        fl_prog_out,
	input wire logic        fl_erase_out,
	input wire logic [1:0]  fl_erase_bank_out,
	input wire logic [1:0]  fl_wmask_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);
	a_done_pulse: assert property (done_out |=> !done_out)
		else $error("done longer than one cycle");
	a_result_on_done: assert property ($changed(result_out) |-> done_out)
		else $error("result moved without done");
	a_busy_blocks: assert property (cpu_req_in && busy_out |=> cpu_blocked_out)
		else $error("access while busy not blocked");
	a_blocked_zero: assert property (cpu_blocked_out |-> cpu_rdata_out == 32'h0000_0000)
		else $error("blocked access returned data");
	a_idle_quiet: assert property (!busy_out |-> !fl_prog_out && !fl_erase_out)
		else $error("array pulse while idle");
	a_read_three: assert property (cpu_req_in && cpu_hit_out && !busy_out && !protect_in
		&& !$past(cpu_req_in) && !$past(cpu_req_in, 2) |-> ##3 cpu_ack_out)
		else $error("read not answered in three cycles");
	a_view_block: assert property (cpu_req_in && cpu_hit_out && !busy_out && protect_in
		&& cpu_ext_view_in && !cpu_fetch_in && !$past(cpu_req_in) && !$past(cpu_req_in, 2)
		|-> ##3 cpu_blocked_out)
		else $error("protected view not blocked");
	a_ram_view: assert property (ram_view_block_out == protect_in)
		else $error("ram view block differs from protection");
	a_src_hold: assert property (src_req_out && !src_ack_in |=> src_req_out && $stable(src_addr_out))
		else $error("source request dropped or moved");
	a_erase_bank: assert property (fl_erase_out && $past(fl_erase_out) |-> $stable(fl_erase_bank_out))
		else $error("erase bank changed in pulse");
	a_prog_mask: assert property (fl_prog_out |-> fl_wmask_out != 2'h0 && !fl_erase_out)
		else $error("program pulse without mask");
	cover property (done_out && result_out == 8'h00);
	cover property (cpu_blocked_out);
	cover property (fl_erase_out);
	cover property (src_ack_in && src_req_out);
endmodule : flpes_sequencer_properties
bind flpes_sequencer flpes_sequencer_properties i_props (.*);

/* test/testbench.sv */
// self-checking bench of the flash program/erase sequencer
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_in, resetn_in, seg1_strap_in, flash_enable_bit_in, vpp_present_in, protect_in;
	logic unlock_wr_in, unlock_indirect_in, cpu_req_in, cpu_fetch_in, cpu_ext_view_in, src_ack_in;
	logic busy_out, done_out, src_req_out, cpu_hit_out, cpu_ack_out, cpu_blocked_out;
	logic ram_view_block_out, seg1_map_out, fl_prog_out, fl_erase_out, ack, blk;
	logic [23:0] unlock_addr_in, cpu_addr_in;
	logic [15:0] r0_in, r1_in, r2_in, r3_in, r4_in, ret_r1_out, ret_r2_out, ret_r3_out;
	logic [15:0] src_addr_out, src_data_in;
	logic [7:0]  result_out, res;
	logic [31:0] cpu_rdata_out, fl_wdata_out, fl_rdata_in, rd_d;
	logic [14:0] fl_addr_out;
	logic [1:0]  fl_wmask_out, fl_erase_bank_out;
	int          miscompares, comparisons, cyc;
	flpes_sequencer #(.ERASE_PULSE_NS(32'h0000_00c8)) i_dut (.*);
	flpes_flash_model i_flash (.*);
	initial begin
		ref_clk_in = 1'b0;
		forever #2.5 ref_clk_in = ~ref_clk_in;
	end
	task automatic close_out();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out
	always @(posedge ref_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			miscompares++;
			close_out();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic fire(input logic [15:0] c, a, b, d);
		@(posedge ref_clk_in);
		r0_in <= c;
		r1_in <= a;
		r2_in <= b;
		r3_in <= d;
		unlock_wr_in <= 1'b1;
		@(posedge ref_clk_in);
		unlock_indirect_in <= 1'b1;
		@(posedge ref_clk_in);
		unlock_wr_in <= 1'b0;
		unlock_indirect_in <= 1'b0;
	endtask : fire
	task automatic wt(output logic [7:0] r);
		int n;
		n = 0;
		do begin
			@(posedge ref_clk_in);
			#1;
			n++;
		end while (done_out !== 1'b1 && n < 50000);
		chk({31'h0, done_out}, 32'h0000_0001);
		r = result_out;
	endtask : wt
	task automatic cmd(input logic [15:0] c, a, b, d, input logic [7:0] e);
		fire(c, a, b, d);
		wt(res);
		chk(32'(res), 32'(e));
	endtask : cmd
	task automatic rd(input logic [23:0] a, input logic f, v);
		@(posedge ref_clk_in);
		cpu_req_in <= 1'b1;
		cpu_addr_in <= a;
		cpu_fetch_in <= f;
		cpu_ext_view_in <= v;
		@(posedge ref_clk_in);
		cpu_req_in <= 1'b0;
		#1;
		ack = cpu_ack_out;
		blk = cpu_blocked_out;
		repeat (3) begin
			@(posedge ref_clk_in);
			#1;
			ack = ack | cpu_ack_out;
			blk = blk | cpu_blocked_out;
		end
		rd_d = cpu_rdata_out;
	endtask : rd
	task automatic t_map();
		logic [23:0] a [3] = '{24'h00_7ffc, 24'h00_8000, 24'h01_0000};
		for (int i = 0; i < 3; i++) begin
			@(posedge ref_clk_in);
			cpu_addr_in <= a[i];
			#1;
			chk(32'(cpu_hit_out), 32'(i == 0));
		end
		chk(32'(seg1_map_out), 32'h0000_0000);
		$display("test map done");
	endtask : t_map
	task automatic t_prog();
		cmd({flpes_pkg::CMD_WORD, 4'h0}, 16'h0102, 16'h1234, 16'h0000, flpes_pkg::RES_OK);
		rd(24'h00_0100, 1'b1, 1'b0);
		chk({31'h0, ack}, 32'h0000_0001);
		chk(rd_d, 32'h1234_ffff);
		cmd({flpes_pkg::CMD_DWORD, 4'h0}, 16'h0200, 16'h5678, 16'h9abc, flpes_pkg::RES_OK);
		rd(24'h00_0200, 1'b0, 1'b0);
		chk(rd_d, 32'h9abc_5678);
		cmd({flpes_pkg::CMD_DWORD, 4'h0}, 16'h0206, 16'h0000, 16'h0000, 8'h04);
		cmd({flpes_pkg::CMD_BLOCK, 4'h0}, 16'h0300, 16'h0302, 16'h0040, flpes_pkg::RES_OK);
		rd(24'h00_0300, 1'b1, 1'b0);
		chk(rd_d, 32'ha5e7_a5e5);
		cmd({flpes_pkg::CMD_BLOCK, 4'h0}, 16'h0300, 16'h4300, 16'h0040, 8'h04);
		$display("test program done");
	endtask : t_prog
	task automatic t_errs();
		@(posedge ref_clk_in);
		flash_enable_bit_in <= 1'b0;
		cmd({flpes_pkg::CMD_WORD, 4'h0}, 16'h0400, 16'h0000, 16'h0000, 8'h01);
		flash_enable_bit_in <= 1'b1;
		vpp_present_in <= 1'b0;
		cmd({flpes_pkg::CMD_WORD, 4'h0}, 16'h0400, 16'h0000, 16'h0000, 8'h02);
		vpp_present_in <= 1'b1;
		cmd(16'h1234, 16'h0400, 16'h0000, 16'h0000, flpes_pkg::RES_BAD_CMD);
		rd(24'h00_0400, 1'b1, 1'b0);
		chk(rd_d, 32'hffff_ffff);
		cmd(flpes_pkg::CMD_STATUS, 16'h0000, 16'h0000, 16'h0000, flpes_pkg::RES_OK);
		chk({ret_r1_out, ret_r2_out}, 32'h0005_0001);
		chk(32'(ret_r3_out), 32'h0000_0001);
		$display("test errors done");
	endtask : t_errs
	task automatic t_prot();
		@(posedge ref_clk_in);
		protect_in <= 1'b1;
		rd(24'h00_0200, 1'b0, 1'b1);
		chk({30'h0, blk, ram_view_block_out}, 32'h0000_0003);
		chk(rd_d, 32'h0000_0000);
		rd(24'h00_0200, 1'b1, 1'b1);
		chk(rd_d, 32'h9abc_5678);
		protect_in <= 1'b0;
		$display("test protect done");
	endtask : t_prot
	task automatic t_erase();
		cmd({flpes_pkg::CMD_WORD, 4'h0}, 16'h2000, 16'h0f0f, 16'h0000, flpes_pkg::RES_OK);
		cmd(flpes_pkg::CMD_ERASE, 16'h5555, 16'h0000, 16'h0001, flpes_pkg::RES_BAD_CMD);
		cmd(flpes_pkg::CMD_ERASE, 16'h5554, 16'h0000, 16'h0000, flpes_pkg::RES_BAD_CMD);
		fire(flpes_pkg::CMD_ERASE, 16'h5555, 16'h0000, 16'h0000);
		rd(24'h00_0100, 1'b1, 1'b0);
		chk({30'h0, blk, ack}, 32'h0000_0002);
		wt(res);
		chk(32'(res), 32'(flpes_pkg::RES_OK));
		rd(24'h00_0100, 1'b1, 1'b0);
		chk(rd_d, 32'hffff_ffff);
		rd(24'h00_2000, 1'b1, 1'b0);
		chk(rd_d, 32'hffff_0f0f);
		$display("test erase done");
	endtask : t_erase
	initial begin
		{resetn_in, seg1_strap_in, protect_in, unlock_wr_in, unlock_indirect_in} = 5'h00;
		{cpu_req_in, cpu_fetch_in, cpu_ext_view_in} = 3'h0;
		{flash_enable_bit_in, vpp_present_in} = 2'h3;
		{r0_in, r1_in, r2_in, r3_in} = 64'h0;
		r4_in = 16'h2710;
		unlock_addr_in = 24'h01_8000;
		cpu_addr_in = 24'h00_0000;
		miscompares = 0;
		comparisons = 0;
		cyc = 0;
		repeat (3) @(posedge ref_clk_in);
		resetn_in <= 1'b1;
		repeat (2) @(posedge ref_clk_in);
		t_map();
		t_prog();
		t_errs();
		t_prot();
		t_erase();
		close_out();
	end
endmodule : testbench
